// File: pms_map.vh
`ifndef PMS_MAP_VH
`define PMS_MAP_VH
// Register byte addresses
`define PMS_CTRL_ADDR     12'h000
`define PMS_CLKCFG_ADDR   12'h004
`define PMS_WAKECFG_ADDR  12'h008
`define PMS_STATUS_ADDR   12'h00c
`define PMS_RSTCAUSE_ADDR 12'h010
`define PMS_PINWAKE_ADDR  12'h014
// Mode request codes in CTRL[1:0]
`define PMS_REQ_NONE      2'h0
`define PMS_REQ_IDLE      2'h1
`define PMS_REQ_STANDBY   2'h2
`define PMS_REQ_SHUTDOWN  2'h3
// CLKCFG fields
`define PMS_CLK_HS_RC_BIT 0
`define PMS_CLK_LS_XTAL_BIT 1
`define PMS_CLK_LSOUT_BIT 2
// WAKECFG fields
`define PMS_WAKE_PIN_BIT  0
`define PMS_WAKE_RTC_BIT  1
`define PMS_WAKE_SC_BIT   2
`define PMS_WAKECFG_RST   3'h7
// Reset cause codes
`define PMS_CAUSE_POR     2'h0
`define PMS_CAUSE_PIN     2'h1
`define PMS_CAUSE_WAKEPIN 2'h2
// Wake latencies and system clock period, ns
`define PMS_T_IDLE_NS     14000
`define PMS_T_STBY_NS     151000
`define PMS_T_SHUT_NS     1015000
`define PMS_CLK_NS        20
`endif

// File: pms_counter.v
`timescale 1ns/1ns
// Down counter for wake latency; done is a level while count is zero
module pms_counter #(
   parameter W = 16
) (
   input  wire         clk_sys,
   input  wire         reset_n,
   input  wire         clk_en,
   input  wire         load,
   input  wire [W-1:0] value,
   output wire         done
);
   reg [W-1:0] cnt_r;
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= {W{1'b0}};
      end else if (clk_en) begin
         if (load) begin
            cnt_r <= value;
         end else if (cnt_r != {W{1'b0}}) begin
            cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
         end
      end
   end
   assign done = (cnt_r == {W{1'b0}});
endmodule

// File: pms_sequencer.v
// Local design decisions: the placing of the registers and the APB slave port.
`include "pms_map.vh"
`timescale 1ns/1ns
module pms_sequencer #(
   parameter CW        = 16,
   parameter T_SHUT_CY = (`PMS_T_SHUT_NS + `PMS_CLK_NS - 1) / `PMS_CLK_NS,
   parameter RECHG_CY  = 1000,
   parameter NPIN      = 8
) (
   input  wire            clk_sys,
   input  wire            reset_n,
   input  wire            clk_en,
   input  wire            psel,
   input  wire            penable,
   input  wire            pwrite,
   input  wire [11:0]     paddr,
   input  wire [31:0]     pwdata,
   output reg  [31:0]     prdata,
   output reg             pready,
   output reg             pslverr,
   input  wire            reset_pin_n,
   input  wire            por_event,
   input  wire            brownout_trip,
   input  wire            irq_any,
   input  wire            rtc_event,
   input  wire            sc_event,
   input  wire [NPIN-1:0] pin_in,
   input  wire            lf_xtal_present,
   output reg             cpu_clk_en,
   output reg             cpu_reset,
   output reg             mem_clk_en,
   output reg             periph_pwr,
   output reg             flash_pwr,
   output reg             radio_pwr,
   output reg             hs_clk_en,
   output reg             hs_sel_rc,
   output reg             xtal_doubler_en,
   output reg             ls_sel_rc,
   output reg             ls_clk_en,
   output reg             ls_clk_to_pin,
   output reg             always_on_domain_pwr,
   output reg             sc_pwr,
   output reg             io_latch,
   output reg             supply_recharge,
   output reg             brownout_detector_en,
   output reg             por_detector_en,
   output reg             resume_ctx
);
   localparam [6:0] S_RESET  = 7'h01;
   localparam [6:0] S_ACTIVE = 7'h02;
   localparam [6:0] S_IDLE   = 7'h04;
   localparam [6:0] S_STBY   = 7'h08;
   localparam [6:0] S_SHUT   = 7'h10;
   localparam [6:0] S_PINHLD = 7'h20;
   localparam [6:0] S_WAKE   = 7'h40;
   // Integer figures cut to counter width on purpose
   localparam integer  T_IDLE_I  = (`PMS_T_IDLE_NS + `PMS_CLK_NS - 1) / `PMS_CLK_NS;
   localparam integer  T_STBY_I  = (`PMS_T_STBY_NS + `PMS_CLK_NS - 1) / `PMS_CLK_NS;
   localparam integer  T_SHUT_I  = T_SHUT_CY;
   localparam integer  RECHG_I   = RECHG_CY;
   localparam [CW-1:0] T_IDLE_CY = T_IDLE_I[CW-1:0];
   localparam [CW-1:0] T_STBY_CY = T_STBY_I[CW-1:0];
   localparam [CW-1:0] T_SHUT_W  = T_SHUT_I[CW-1:0];
   localparam [CW-1:0] RECHG_W   = RECHG_I[CW-1:0];

   // Pin synchronisers; first stages are read only by the second
   reg            rpin_s1_r, rpin_s2_r;
   reg            por_s1_r, por_s2_r;
   reg            bod_s1_r, bod_s2_r;
   reg            rtc_s1_r, rtc_s2_r;
   reg            sc_s1_r, sc_s2_r;
   reg [NPIN-1:0] pin_s1_r, pin_s2_r, pin_ref_r;

   reg [6:0]      state_r, state_nxt;
   reg [1:0]      req_r;
   reg [2:0]      clkcfg_r;
   reg [2:0]      wakecfg_r;
   reg [NPIN-1:0] pinwake_r;
   reg [1:0]      cause_r;
   reg            lock_r;
   reg            resume_r;
   reg [CW-1:0]   rechg_cnt_r;
   reg            ld;
   reg [CW-1:0]   ld_val;
   wire           lat_done;

   wire wr_en = psel & penable & pwrite & clk_en;
   wire rd_en = psel & ~penable & ~pwrite;

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rpin_s1_r <= 1'b1;
         rpin_s2_r <= 1'b1;
         por_s1_r  <= 1'b0;
         por_s2_r  <= 1'b0;
         bod_s1_r  <= 1'b0;
         bod_s2_r  <= 1'b0;
         rtc_s1_r  <= 1'b0;
         rtc_s2_r  <= 1'b0;
         sc_s1_r   <= 1'b0;
         sc_s2_r   <= 1'b0;
         pin_s1_r  <= {NPIN{1'b0}};
         pin_s2_r  <= {NPIN{1'b0}};
      end else if (clk_en) begin
         rpin_s1_r <= reset_pin_n;
         rpin_s2_r <= rpin_s1_r;
         por_s1_r  <= por_event;
         por_s2_r  <= por_s1_r;
         bod_s1_r  <= brownout_trip;
         bod_s2_r  <= bod_s1_r;
         rtc_s1_r  <= rtc_event;
         rtc_s2_r  <= rtc_s1_r;
         sc_s1_r   <= sc_event;
         sc_s2_r   <= sc_s1_r;
         pin_s1_r  <= pin_in;
         pin_s2_r  <= pin_s1_r;
      end
   end

   wire pin_change  = |((pin_s2_r ^ pin_ref_r) & pinwake_r);
   wire stby_wake   = (pin_change & wakecfg_r[`PMS_WAKE_PIN_BIT]) |
                      (rtc_s2_r & wakecfg_r[`PMS_WAKE_RTC_BIT]) |
                      (sc_s2_r & wakecfg_r[`PMS_WAKE_SC_BIT]);

   pms_counter #(
      .W (CW)
   ) u_lat (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .clk_en  (clk_en),
      .load    (ld),
      .value   (ld_val),
      .done    (lat_done)
   );

   always @* begin
      state_nxt = state_r;
      ld        = 1'b0;
      ld_val    = T_IDLE_CY;
      if (por_s2_r) begin
         // Power-on reset wins from every mode
         state_nxt = S_RESET;
         ld        = 1'b1;
         ld_val    = T_SHUT_W;
      end else if (!rpin_s2_r) begin
         state_nxt = S_PINHLD;
      end else begin
         case (state_r)
            S_RESET: begin
               if (lat_done) begin
                  state_nxt = S_ACTIVE;
               end
            end
            S_ACTIVE: begin
               // Low-power entry only from here
               case (req_r)
                  `PMS_REQ_IDLE:     state_nxt = S_IDLE;
                  `PMS_REQ_STANDBY:  state_nxt = S_STBY;
                  `PMS_REQ_SHUTDOWN: state_nxt = S_SHUT;
                  default:           state_nxt = S_ACTIVE;
               endcase
            end
            S_IDLE: begin
               if (irq_any | stby_wake) begin
                  state_nxt = S_WAKE;
                  ld        = 1'b1;
                  ld_val    = T_IDLE_CY;
               end
            end
            S_STBY: begin
               if (stby_wake) begin
                  state_nxt = S_WAKE;
                  ld        = 1'b1;
                  ld_val    = T_STBY_CY;
               end
            end
            S_SHUT: begin
               if (pin_change) begin
                  state_nxt = S_RESET;
                  ld        = 1'b1;
                  ld_val    = T_SHUT_W;
               end
            end
            S_PINHLD: begin
               // Released pin runs the full reset sequence
               state_nxt = S_RESET;
               ld        = 1'b1;
               ld_val    = T_SHUT_W;
            end
            S_WAKE: begin
               if (lat_done && !lock_r) begin
                  state_nxt = S_ACTIVE;
               end
            end
            default: state_nxt = S_RESET;
         endcase
      end
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_r     <= S_RESET;
         req_r       <= `PMS_REQ_NONE;
         clkcfg_r    <= 3'h0;
         wakecfg_r   <= `PMS_WAKECFG_RST;
         pinwake_r   <= {NPIN{1'b0}};
         pin_ref_r   <= {NPIN{1'b0}};
         cause_r     <= `PMS_CAUSE_POR;
         lock_r      <= 1'b0;
         resume_r    <= 1'b0;
         rechg_cnt_r <= {CW{1'b0}};
      end else if (clk_en) begin
         state_r <= state_nxt;
         // Request is consumed on entry so a wake does not re-enter
         if (state_r == S_ACTIVE && state_nxt != S_ACTIVE) begin
            req_r <= `PMS_REQ_NONE;
         end else if (wr_en && paddr == `PMS_CTRL_ADDR) begin
            req_r <= pwdata[1:0];
         end
         if (wr_en && paddr == `PMS_CLKCFG_ADDR) begin
            clkcfg_r <= pwdata[2:0];
         end
         if (wr_en && paddr == `PMS_WAKECFG_ADDR) begin
            wakecfg_r <= pwdata[2:0];
         end
         if (wr_en && paddr == `PMS_PINWAKE_ADDR) begin
            pinwake_r <= pwdata[NPIN-1:0];
         end
         if (state_r == S_ACTIVE) begin
            pin_ref_r <= pin_s2_r;
         end
         // Shutdown, pin-hold and reset entry lose clock and wake configuration; shutdown keeps the pin-wake mask
         if (state_nxt == S_SHUT || state_nxt == S_PINHLD || state_nxt == S_RESET && state_r != S_RESET) begin
            clkcfg_r  <= 3'h0;
            wakecfg_r <= `PMS_WAKECFG_RST;
            if (state_nxt != S_SHUT) begin
               pinwake_r <= {NPIN{1'b0}};
            end
         end
         if (por_s2_r) begin
            cause_r <= `PMS_CAUSE_POR;
         end else if (state_r == S_PINHLD) begin
            cause_r <= `PMS_CAUSE_PIN;
         end else if (state_r == S_SHUT && state_nxt == S_RESET) begin
            cause_r <= `PMS_CAUSE_WAKEPIN;
         end
         // Brownout only seen in standby while detector is disabled
         if (state_r == S_RESET || state_r == S_PINHLD) begin
            lock_r <= 1'b0;
         end else if (bod_s2_r && state_r == S_STBY && !brownout_detector_en) begin
            lock_r <= 1'b1;
         end
         resume_r <= (state_r == S_STBY) ? 1'b1 :
                     (state_r == S_RESET) ? 1'b0 : resume_r;
         if (state_r == S_STBY) begin
            rechg_cnt_r <= (rechg_cnt_r == {CW{1'b0}}) ? RECHG_W : rechg_cnt_r - {{(CW-1){1'b0}}, 1'b1};
         end else begin
            rechg_cnt_r <= {CW{1'b0}};
         end
      end
   end

   wire recharge = (state_r == S_STBY) && (rechg_cnt_r == {CW{1'b0}});

   // APB: zero wait, unmapped read zero with error
   wire mapped = (paddr == `PMS_CTRL_ADDR) || (paddr == `PMS_CLKCFG_ADDR) ||
                 (paddr == `PMS_WAKECFG_ADDR) || (paddr == `PMS_STATUS_ADDR) ||
                 (paddr == `PMS_RSTCAUSE_ADDR) || (paddr == `PMS_PINWAKE_ADDR);

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         if (rd_en) begin
            case (paddr)
               `PMS_CTRL_ADDR:     prdata <= {30'h0, req_r};
               `PMS_CLKCFG_ADDR:   prdata <= {29'h0, clkcfg_r};
               `PMS_WAKECFG_ADDR:  prdata <= {29'h0, wakecfg_r};
               `PMS_STATUS_ADDR:   prdata <= {23'h0, lock_r, resume_r, state_r};
               `PMS_RSTCAUSE_ADDR: prdata <= {30'h0, cause_r};
               `PMS_PINWAKE_ADDR:  prdata <= {{(32-NPIN){1'b0}}, pinwake_r};
               default:            prdata <= 32'h0;
            endcase
         end
      end
   end

   wire st_act  = (state_nxt == S_ACTIVE);
   wire st_idle = (state_nxt == S_IDLE);
   wire st_stby = (state_nxt == S_STBY);
   wire st_wake = (state_nxt == S_WAKE);
   wire aon_on  = ~(state_nxt == S_SHUT || state_nxt == S_PINHLD);

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cpu_clk_en           <= 1'b0;
         cpu_reset            <= 1'b1;
         mem_clk_en           <= 1'b0;
         periph_pwr           <= 1'b0;
         flash_pwr            <= 1'b0;
         radio_pwr            <= 1'b0;
         hs_clk_en            <= 1'b0;
         hs_sel_rc            <= 1'b1;
         xtal_doubler_en      <= 1'b0;
         ls_sel_rc            <= 1'b1;
         ls_clk_en            <= 1'b0;
         ls_clk_to_pin        <= 1'b0;
         always_on_domain_pwr <= 1'b0;
         sc_pwr               <= 1'b0;
         io_latch             <= 1'b0;
         supply_recharge      <= 1'b0;
         brownout_detector_en <= 1'b0;
         por_detector_en      <= 1'b1;
         resume_ctx           <= 1'b0;
      end else if (clk_en) begin
         cpu_clk_en           <= st_act;
         cpu_reset            <= (state_nxt == S_RESET) || !aon_on;
         mem_clk_en           <= st_act;
         periph_pwr           <= st_act | st_idle | st_wake;
         flash_pwr            <= st_act | st_idle | st_wake;
         radio_pwr            <= st_act | st_idle;
         hs_clk_en            <= st_act | st_idle | st_wake;
         hs_sel_rc            <= clkcfg_r[`PMS_CLK_HS_RC_BIT];
         xtal_doubler_en      <= (st_act | st_idle | st_wake) & ~clkcfg_r[`PMS_CLK_HS_RC_BIT];
         ls_sel_rc            <= ~(lf_xtal_present & clkcfg_r[`PMS_CLK_LS_XTAL_BIT]);
         ls_clk_en            <= aon_on;
         ls_clk_to_pin        <= aon_on & clkcfg_r[`PMS_CLK_LSOUT_BIT];
         always_on_domain_pwr <= aon_on;
         sc_pwr               <= aon_on;
         io_latch             <= st_stby | (state_nxt == S_SHUT);
         supply_recharge      <= ~st_stby | recharge;
         brownout_detector_en <= st_act | st_idle | st_wake | (st_stby & recharge);
         por_detector_en      <= 1'b1;
         resume_ctx           <= st_wake & resume_r;
      end
   end
endmodule

// File: pms_checker.sv
`timescale 1ns/1ns
module pms_checker (
   input wire clk_sys,
   input wire reset_n,
   input wire irq_any,
   input wire reset_pin_n,
   input wire lf_xtal_present,
   input wire cpu_clk_en,
   input wire cpu_reset,
   input wire mem_clk_en,
   input wire periph_pwr,
   input wire flash_pwr,
   input wire radio_pwr,
   input wire hs_clk_en,
   input wire hs_sel_rc,
   input wire xtal_doubler_en,
   input wire ls_sel_rc,
   input wire ls_clk_en,
   input wire always_on_domain_pwr,
   input wire sc_pwr,
   input wire io_latch,
   input wire supply_recharge,
   input wire brownout_detector_en,
   input wire por_detector_en,
   input wire resume_ctx
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   wire stby = io_latch && always_on_domain_pwr;
   wire idle = !cpu_clk_en && periph_pwr && !io_latch && !cpu_reset;
   sequence idle_irq_s; idle && irq_any; endsequence
   sequence slept_s; !cpu_clk_en [*8]; endsequence
   sequence pin_held_s; !reset_pin_n [*4]; endsequence
   stby_off_a: assert property (stby |-> !flash_pwr && !radio_pwr && !periph_pwr && !hs_clk_en)
      else $error("standby left a domain on");
   shut_off_a: assert property (io_latch && !always_on_domain_pwr |-> !sc_pwr && !periph_pwr && !cpu_clk_en)
      else $error("shutdown left a domain on");
   irq_wake_a: assert property (idle_irq_s |=> slept_s ##[600:710] cpu_clk_en)
      else $error("idle wake latency wrong");
   clk_pair_a: assert property (!cpu_reset |-> cpu_clk_en == mem_clk_en)
      else $error("cpu and memory clocks differ");
   por_live_a: assert property (always_on_domain_pwr || io_latch |-> por_detector_en)
      else $error("power-on detector off");
   bod_duty_a: assert property (stby && !supply_recharge |-> !brownout_detector_en)
      else $error("brownout detector on between recharges");
   doubler_on_a: assert property (hs_clk_en && !hs_sel_rc |-> xtal_doubler_en)
      else $error("crystal used without doubler");
   ls_rc_a: assert property (ls_clk_en && !lf_xtal_present |-> ls_sel_rc)
      else $error("low-speed crystal used but absent");
   pin_hold_a: assert property (pin_held_s |=> cpu_reset && !cpu_clk_en && !flash_pwr)
      else $error("held reset pin did not stop device");
   no_resume_a: assert property (cpu_reset |-> !resume_ctx)
      else $error("resume flagged during reset");
endmodule
bind pms_sequencer pms_checker chk (.clk_sys, .reset_n, .irq_any, .reset_pin_n, .lf_xtal_present, .cpu_clk_en,
   .cpu_reset, .mem_clk_en, .periph_pwr, .flash_pwr, .radio_pwr, .hs_clk_en, .hs_sel_rc, .xtal_doubler_en,
   .ls_sel_rc, .ls_clk_en, .always_on_domain_pwr, .sc_pwr, .io_latch, .supply_recharge, .brownout_detector_en,
   .por_detector_en, .resume_ctx);

// File: pms_wake_src.sv
`timescale 1ns/1ns
module pms_wake_src (
   input  wire       clk_sys,
   input  wire       go_irq,
   input  wire       go_rtc,
   input  wire       go_sc,
   input  wire       go_pin,
   input  wire       go_bod,
   output reg        irq_any,
   output wire       rtc_event,
   output wire       sc_event,
   output reg  [7:0] pin_in,
   output reg        brownout_trip
);
   reg [2:0] rtc_c = 3'h0;
   reg [2:0] sc_c = 3'h0;
   initial irq_any = 1'b0;
   initial pin_in = 8'h00;
   initial brownout_trip = 1'b0;
   // Supply stays in range unless a scenario drops it on purpose
   // Synchronised events held long enough to pass two flops
   assign rtc_event = |rtc_c;
   assign sc_event = |sc_c;
   always @(posedge clk_sys) begin
      irq_any <= go_irq;
      brownout_trip <= go_bod;
      rtc_c <= go_rtc ? 3'h4 : rtc_c - {2'h0, |rtc_c};
      sc_c <= go_sc ? 3'h4 : sc_c - {2'h0, |sc_c};
      if (go_pin) pin_in[0] <= ~pin_in[0];
   end
endmodule

// File: pms_sequencer_tb.sv
`include "pms_map.vh"
`timescale 1ns/1ns
module pms_sequencer_tb;
   logic        clk_sys = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, reset_pin_n = 1;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, q;
   logic        go_irq = 0, go_rtc = 0, go_sc = 0, go_pin = 0, go_bod = 0, lf_xtal = 0, e;
   wire  [31:0] prdata;
   wire  [7:0]  pin_in;
   wire         pready, pslverr, irq_any, rtc_event, sc_event, brownout_trip, cpu_clk_en, cpu_reset;
   wire         mem_clk_en, periph_pwr, flash_pwr, radio_pwr, hs_clk_en, hs_sel_rc, xtal_doubler_en;
   wire         ls_sel_rc, ls_clk_en, ls_clk_to_pin, always_on_domain_pwr, sc_pwr, io_latch;
   wire         supply_recharge, brownout_detector_en, por_detector_en, resume_ctx;
   int          fail_count = 0, samples_checked = 0, cyc = 0, n;
   // Sim-length counts; shutdown wake scaled down from its full figure
   pms_sequencer #(.T_SHUT_CY(20), .RECHG_CY(10)) DUT (.clk_sys, .reset_n, .clk_en(1'b1), .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .reset_pin_n, .por_event(1'b0), .brownout_trip,
      .irq_any, .rtc_event, .sc_event, .pin_in, .lf_xtal_present(lf_xtal), .cpu_clk_en, .cpu_reset, .mem_clk_en,
      .periph_pwr, .flash_pwr, .radio_pwr, .hs_clk_en, .hs_sel_rc, .xtal_doubler_en, .ls_sel_rc, .ls_clk_en,
      .ls_clk_to_pin, .always_on_domain_pwr, .sc_pwr, .io_latch, .supply_recharge, .brownout_detector_en,
      .por_detector_en, .resume_ctx);
   pms_wake_src src (.clk_sys, .go_irq, .go_rtc, .go_sc, .go_pin, .go_bod, .irq_any, .rtc_event, .sc_event, .pin_in,
      .brownout_trip);
   initial forever #10 clk_sys = ~clk_sys;
   task close_out;
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fail_count++;
         close_out;
      end
   end
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Master waits on pready with no assumed latency
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   task rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(nm, q, exp);
   endtask
   task pause(input int c);
      repeat (c) @(posedge clk_sys);
   endtask
   task wake_time;
      n = 0;
      while (cpu_clk_en !== 1'b1 && n < 9000) begin
         @(posedge clk_sys);
         n++;
      end
   endtask
   task t_reset;
      rd("status", `PMS_STATUS_ADDR, 32'h2);
      rd("cause_por", `PMS_RSTCAUSE_ADDR, `PMS_CAUSE_POR);
      rd("wakecfg", `PMS_WAKECFG_ADDR, `PMS_WAKECFG_RST);
      apb(1'b0, 12'h0f0, 32'h0);
      check("unmapped", {31'h0, e}, 32'h1);
      check("por_det", por_detector_en, 1'b1);
   endtask
   task t_clk;
      apb(1'b1, `PMS_CLKCFG_ADDR, 32'h6);
      pause(4);
      check("doubler", {hs_sel_rc, xtal_doubler_en}, 2'h1);
      check("ls_rc", ls_sel_rc, 1'b1);
      check("ls_pin", ls_clk_to_pin, 1'b1);
      lf_xtal <= 1'b1;
      pause(4);
      check("ls_xtal", ls_sel_rc, 1'b0);
      apb(1'b1, `PMS_CLKCFG_ADDR, 32'h1);
      pause(4);
      check("hs_rc", hs_sel_rc, 1'b1);
   endtask
   task t_idle;
      apb(1'b1, `PMS_CTRL_ADDR, `PMS_REQ_IDLE);
      pause(8);
      check("idle_gate", {cpu_clk_en, mem_clk_en, periph_pwr}, 3'h1);
      go_irq <= 1'b1;
      @(posedge clk_sys);
      go_irq <= 1'b0;
      wake_time;
      check("idle_lat", n >= 698 && n <= 706, 1'b1);
   endtask
   task t_stby;
      apb(1'b1, `PMS_WAKECFG_ADDR, 32'h2);
      apb(1'b1, `PMS_CTRL_ADDR, `PMS_REQ_STANDBY);
      pause(8);
      check("stby_pwr", {io_latch, always_on_domain_pwr, periph_pwr, flash_pwr}, 4'hc);
      go_sc <= 1'b1;
      @(posedge clk_sys);
      go_sc <= 1'b0;
      go_irq <= 1'b1;
      @(posedge clk_sys);
      go_irq <= 1'b0;
      pause(30);
      check("stby_hold", {cpu_clk_en, io_latch}, 2'h1);
      go_rtc <= 1'b1;
      @(posedge clk_sys);
      go_rtc <= 1'b0;
      pause(10);
      check("resume", {resume_ctx, cpu_reset}, 2'h2);
      wake_time;
      check("stby_lat", n >= 7535 && n <= 7555, 1'b1);
      rd("resume_stat", `PMS_STATUS_ADDR, 32'h82);
      rd("kept_cfg", `PMS_WAKECFG_ADDR, 32'h2);
   endtask
   task t_shut;
      apb(1'b1, `PMS_PINWAKE_ADDR, 32'h1);
      apb(1'b1, `PMS_CTRL_ADDR, `PMS_REQ_SHUTDOWN);
      pause(8);
      check("shut_pwr", {always_on_domain_pwr, sc_pwr, io_latch}, 3'h1);
      go_pin <= 1'b1;
      @(posedge clk_sys);
      go_pin <= 1'b0;
      wake_time;
      check("shut_lat", n >= 20 && n <= 40, 1'b1);
      check("no_resume", resume_ctx, 1'b0);
      rd("reset_stat", `PMS_STATUS_ADDR, 32'h2);
      rd("cause_wake", `PMS_RSTCAUSE_ADDR, `PMS_CAUSE_WAKEPIN);
      rd("lost_cfg", `PMS_WAKECFG_ADDR, `PMS_WAKECFG_RST);
   endtask
   task t_pin;
      reset_pin_n <= 1'b0;
      pause(8);
      go_rtc <= 1'b1;
      @(posedge clk_sys);
      go_rtc <= 1'b0;
      pause(20);
      check("pin_held", {cpu_reset, cpu_clk_en}, 2'h2);
      reset_pin_n <= 1'b1;
      wake_time;
      check("pin_lat", n >= 20 && n <= 40, 1'b1);
      rd("cause_pin", `PMS_RSTCAUSE_ADDR, `PMS_CAUSE_PIN);
      rd("lock_clear", `PMS_STATUS_ADDR, 32'h2);
   endtask
   // Supply dropped between recharges; wake must stall until reset pin
   task t_lock;
      apb(1'b1, `PMS_CTRL_ADDR, `PMS_REQ_STANDBY);
      go_bod <= 1'b1;
      pause(40);
      go_bod <= 1'b0;
      go_rtc <= 1'b1;
      @(posedge clk_sys);
      go_rtc <= 1'b0;
      pause(7600);
      check("bod_lock", cpu_clk_en, 1'b0);
      rd("lock_stat", `PMS_STATUS_ADDR, 32'h1c0);
   endtask
   initial begin
      pause(16);
      reset_n <= 1'b1;
      pause(6);
      t_reset;
      t_clk;
      t_idle;
      t_stby;
      t_shut;
      t_lock;
      t_pin;
      close_out;
   end
endmodule
